/* File: mi_model.sv */
// machine interface model answering the gear change handshake
// assumes range codes registered on pclk; shift time set by HOLD
`timescale 1ns/10ps
`default_nettype none

module mi_model
   import spindle_pkg::*;
#(
   parameter int HOLD = 40
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire range_out_s range_select_codes,
   output logic function_ready
);
   // ----------------------------------------------------------------
   // shift timing
   // ----------------------------------------------------------------
   range_out_s seen_q;
   int cnt_q;

   // lag before raising, like a real gearbox
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_q <= '0;
         cnt_q <= 0;
         function_ready <= 1'b0;
      end else begin
         seen_q <= range_select_codes;
         if (range_select_codes != seen_q) begin
            cnt_q <= HOLD + 4;
         end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
         end
         function_ready <= (cnt_q > 1) && (cnt_q <= HOLD);
      end
   end
endmodule : mi_model

`default_nettype wire

/* File: spindle_checker.sv */
// concurrent checks on the spindle block ports
// assumes a bind from the bench top file and a single pclk domain
`timescale 1ns/10ps
`default_nettype none

module spindle_checker
   import spindle_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic function_ready,
   input wire logic spindle_permitted,
   input wire logic at_standstill,
   input wire range_out_s range_select_codes,
   input wire logic signed [16:0] analog_out_mv,
   input wire logic rotation_enable,
   input wire logic loop_closed,
   input wire logic standstill_error
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // port relations
   // ----------------------------------------------------------------
   zero_wait_a: assert property (psel && penable |-> pready)
      else $error("access without ready");
   err_access_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access");
   unmapped_err_a: assert property (psel && penable && (paddr > 8'h44 || paddr[1:0] != 2'b00)
      |-> pslverr) else $error("unmapped access not refused");
   unmapped_zero_a: assert property (psel && !penable && !pwrite && paddr > 8'h44
      |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
   inhibit_out_a: assert property (!spindle_permitted |=> analog_out_mv == '0)
      else $error("output while inhibited");
   inhibit_rot_a: assert property (rotation_enable |-> $past(spindle_permitted))
      else $error("rotation while inhibited");
   err_standstill_a: assert property ($rose(standstill_error) |->
      $past(at_standstill)) else $error("error while moving");
   err_sticky_a: assert property (standstill_error && !(psel && penable && pwrite &&
      paddr == 8'h3C && pwdata[0]) |=> standstill_error) else $error("error lost");
   code_hold_a: assert property (function_ready |=>
      $stable(range_select_codes)) else $error("code changed while shifting");
   mode_hold_a: assert property (!$past(psel && penable && pwrite) |->
      $stable(loop_closed)) else $error("mode changed without write");
endmodule : spindle_checker

`default_nettype wire

/* File: spindle_params.svh */
// offsets, fields, reset values and timing counts
// assumes inclusion by its bare name from the design
`ifndef SPINDLE_PARAMS_SVH
`define SPINDLE_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CFG 8'h00
`define OFF_LIMIT 8'h04
`define OFF_MARKER 8'h08
`define OFF_RMAX0 8'h0C
`define OFF_VMAX 8'h1C
`define OFF_VMIN 8'h20
`define OFF_VGC 8'h24
`define OFF_IVAL 8'h28
`define OFF_PDUR 8'h2C
`define OFF_SCMD 8'h30
`define OFF_SPIN 8'h34
`define OFF_DADDR 8'h38
`define OFF_STAT 8'h3C
`define OFF_AOUT 8'h40
`define OFF_STOP 8'h44

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_EXTRA 0
`define CFG_MODE_LO 1
`define CFG_MODE_HI 2
`define CFG_SPCFG 3
`define SCMD_RANGE_LO 14
`define SCMD_RANGE_HI 15
`define SCMD_PROG 16
`define SPIN_CW 0
`define SPIN_CCW 1
`define SPIN_OSTOP 2
`define STAT_ERR 0

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define RST_VMAX 16'h1F40
`define SPEED_MAX 14'h270F

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 100
`define STEP_MS 50
`define STEP_CYCLES (`STEP_MS * 1000 * `CLK_MHZ)

`endif

/* File: spindle_pkg.sv */
// types shared by the spindle range and gear change logic
// assumes the params header sits in the same folder
package spindle_pkg;

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      st_run = 4'b0001,
      st_gc_level = 4'b0010,
      st_gc_code = 4'b0100,
      st_gc_busy = 4'b1000
   } gc_state_e;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic spcfg;
      logic [1:0] mode;
      logic extra;
   } cfg_s;

   typedef struct packed {
      logic [1:0] code;
      logic valid;
   } range_out_s;

   typedef logic signed [14:0] rmax_t;

endpackage : spindle_pkg

/* File: spindle_range_gear_change_control.sv */
// spindle speed range selection, gear change handshake and analog output
// assumes an apb master on pclk and machine interface inputs synchronous to pclk
//
// Function
// - at standstill, following distance growth beyond limit raises an error
// - extra offset on: stop offset is marker offset plus d value
// - extra offset off: d value ignored, marker offset only
// - four ranges, selected by four consecutive range codes
// - automatic mode picks the range holding the speed unless one is programmed
// - fitting speed updates output at once, else a range change starts
// - range change drives gear level first, then outputs the new code
// - after the drop the new range is active and output goes to speed level
// - spindle permitted low inhibits rotation at any time
// - mode 0 manual open, 1 auto open, 2 manual closed, 3 auto closed
// - range mode unavailable while spindle configuration is zero
// - each range holds a signed maximum speed up to 9999; range maximum writes are not limited, any 15-bit signed value is stored
// - range maximum sign sets output polarity for both directions
// - maximum analog voltage held in millivolts
// - minimum analog voltage held in millivolts
// - gear change voltage held in millivolts
// - pulse interval in 50 ms steps, zero gives steady voltage
// - alternation drives gear voltage positive and negative per pulse
// - pulse duration in 50 ms steps up to 255, zero gives steady voltage
//
// Implementation choices: the register addresses and the APB register port.
`include "spindle_params.svh"
`timescale 1ns/10ps
`default_nettype none

module spindle_range_gear_change_control
   import spindle_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `STEP_CYCLES,
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned FD_W = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic function_ready,
   input wire logic spindle_permitted,
   input wire logic at_standstill,
   input wire logic [FD_W-1:0] following_distance,
   output logic signed [16:0] analog_out_mv,
   output range_out_s range_select_codes,
   output logic rotation_enable,
   output logic loop_closed,
   output logic standstill_error,
   output logic signed [20:0] stop_offset
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (STEP_CYCLES < 1) begin : g_bad_step
      $error("STEP_CYCLES must be at least one");
   end
   if (ADDR_W < 7 || FD_W < 2 || FD_W > 31) begin : g_bad_w
      $error("ADDR_W or FD_W out of range");
   end

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [13:0] mag15(input rmax_t v);
      logic [14:0] a;
      a = v[14] ? 15'(-v) : 15'(v);
      return a[13:0];
   endfunction : mag15

   function automatic logic [15:0] scale_mv(input logic [13:0] spd,
                                            input logic [13:0] rm,
                                            input logic [15:0] vmax);
      logic [29:0] p;
      logic [29:0] q;
      p = 30'(spd) * 30'(vmax);
      q = (rm == 14'h0000) ? 30'h0000_0000 : p / 30'(rm);
      return (q > 30'(vmax)) ? vmax : q[15:0];
   endfunction : scale_mv

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   cfg_s cfg_q;
   logic [19:0] limit_q;
   logic [18:0] marker_q;
   rmax_t rmax_q [4];
   logic [15:0] vmax_q;
   logic [15:0] vmin_q;
   logic [15:0] vgc_q;
   logic [7:0] ival_q;
   logic [7:0] pdur_q;
   logic [13:0] speed_q;
   logic cw_q;
   logic ccw_q;
   logic signed [19:0] daddr_q;
   logic err_q;
   gc_state_e state_q;
   logic [1:0] active_q;
   logic [1:0] target_q;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic [7:0] addr;
   logic setup;
   logic access;
   logic wr;
   logic mapped;
   logic busy;
   logic refuse;
   logic [1:0] mode_eff;
   logic auto_mode;

   assign addr = paddr[7:0];
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign busy = (state_q != st_run);
   assign mode_eff = cfg_q.spcfg ? cfg_q.mode : 2'b00;
   assign auto_mode = mode_eff[0];
   assign loop_closed = mode_eff[1];
   assign mapped = (addr[1:0] == 2'b00) && (addr <= `OFF_STOP) && ((paddr >> 8) == '0);
   // speed commands mid gear change are refused rather than queued
   assign refuse = pwrite && (addr == `OFF_SCMD) && busy;
   assign wr = access & pwrite & mapped & ~refuse;
   assign pready = 1'b1;
   assign pslverr = access & (~mapped | refuse);

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= '0;
         limit_q <= '0;
         marker_q <= '0;
         vmax_q <= `RST_VMAX;
         vmin_q <= '0;
         vgc_q <= '0;
         ival_q <= '0;
         pdur_q <= '0;
         daddr_q <= '0;
         for (int i = 0; i < 4; i++) begin
            rmax_q[i] <= '0;
         end
      end else if (wr) begin
         unique case (addr)
            `OFF_CFG: cfg_q <= pwdata[`CFG_SPCFG:`CFG_EXTRA];
            `OFF_LIMIT: limit_q <= pwdata[19:0];
            `OFF_MARKER: marker_q <= pwdata[18:0];
            `OFF_VMAX: vmax_q <= pwdata[15:0];
            `OFF_VMIN: vmin_q <= pwdata[15:0];
            `OFF_VGC: vgc_q <= pwdata[15:0];
            `OFF_IVAL: ival_q <= pwdata[7:0];
            `OFF_PDUR: pdur_q <= pwdata[7:0];
            `OFF_DADDR: daddr_q <= pwdata[19:0];
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (addr == 8'(`OFF_RMAX0 + 4 * i)) begin
                     rmax_q[i] <= pwdata[14:0];
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // direction and oriented stop
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cw_q <= 1'b0;
         ccw_q <= 1'b0;
         stop_offset <= '0;
      end else if (wr && addr == `OFF_SPIN) begin
         cw_q <= pwdata[`SPIN_CW];
         ccw_q <= pwdata[`SPIN_CCW] & ~pwdata[`SPIN_CW];
         if (pwdata[`SPIN_OSTOP]) begin
            if (cfg_q.extra) begin
               stop_offset <= 21'(marker_q) + 21'(daddr_q);
            end else begin
               stop_offset <= 21'(marker_q);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // range selection
   // ----------------------------------------------------------------
   logic [1:0] pick;
   logic [13:0] new_spd;
   logic [1:0] new_tgt;
   logic new_cmd;

   assign new_spd = (pwdata[13:0] > `SPEED_MAX) ? `SPEED_MAX : pwdata[13:0];
   assign new_cmd = wr && (addr == `OFF_SCMD);

   // ranges assumed ascending and non-overlapping; above all goes to the top
   always_comb begin
      pick = 2'd3;
      for (int i = 3; i >= 0; i--) begin
         if (new_spd <= mag15(rmax_q[i])) begin
            pick = 2'(i);
         end
      end
   end

   always_comb begin
      if (pwdata[`SCMD_PROG]) begin
         new_tgt = pwdata[`SCMD_RANGE_HI:`SCMD_RANGE_LO];
      end else if (auto_mode) begin
         new_tgt = pick;
      end else begin
         new_tgt = active_q;
      end
   end

   // ----------------------------------------------------------------
   // gear change sequence
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= st_run;
         active_q <= 2'd0;
         target_q <= 2'd0;
         speed_q <= '0;
         range_select_codes <= '0;
      end else begin
         unique case (state_q)
            st_run: begin
               if (new_cmd) begin
                  speed_q <= new_spd;
                  target_q <= new_tgt;
                  if (new_tgt != active_q) begin
                     state_q <= st_gc_level;
                  end
               end
            end
            st_gc_level: begin
               state_q <= st_gc_code;
            end
            st_gc_code: begin
               range_select_codes.code <= target_q;
               range_select_codes.valid <= 1'b1;
               if (function_ready) begin
                  state_q <= st_gc_busy;
               end
            end
            st_gc_busy: begin
               if (!function_ready) begin
                  state_q <= st_run;
                  active_q <= target_q;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // 50 ms step divider and rotation pulses
   // ----------------------------------------------------------------
   logic [31:0] div_q;
   logic step;
   logic [7:0] pcnt_q;
   logic pon_q;
   logic pneg_q;
   logic alt;

   assign step = (div_q == 32'(STEP_CYCLES - 1));
   assign alt = (ival_q != 8'h00) && (pdur_q != 8'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
      end else begin
         div_q <= step ? 32'h0000_0000 : div_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcnt_q <= '0;
         pon_q <= 1'b1;
         pneg_q <= 1'b0;
      end else if (state_q == st_run) begin
         pcnt_q <= '0;
         pon_q <= 1'b1;
         pneg_q <= 1'b0;
      end else if (alt && step) begin
         if (pon_q && pcnt_q + 8'h01 >= pdur_q) begin
            pcnt_q <= '0;
            pon_q <= 1'b0;
         end else if (!pon_q && pcnt_q + 8'h01 >= ival_q) begin
            pcnt_q <= '0;
            pon_q <= 1'b1;
            pneg_q <= ~pneg_q;
         end else begin
            pcnt_q <= pcnt_q + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // analog output
   // ----------------------------------------------------------------
   logic [15:0] raw_mv;
   logic [15:0] clamp_mv;
   logic neg_pol;
   logic turning;
   logic signed [16:0] aout_d;

   assign raw_mv = scale_mv(speed_q, mag15(rmax_q[active_q]), vmax_q);
   assign turning = cw_q | ccw_q;
   // sign of the range maximum flips both directions
   assign neg_pol = rmax_q[active_q][14] ^ ccw_q;

   always_comb begin
      if (raw_mv < vmin_q) begin
         clamp_mv = vmin_q;
      end else if (raw_mv > vmax_q) begin
         clamp_mv = vmax_q;
      end else begin
         clamp_mv = raw_mv;
      end
   end

   always_comb begin
      aout_d = '0;
      if (!spindle_permitted) begin
         aout_d = '0;
      end else if (busy) begin
         if (!alt) begin
            aout_d = 17'(vgc_q);
         end else if (pon_q) begin
            aout_d = pneg_q ? -17'(vgc_q) : 17'(vgc_q);
         end
      end else if (turning && speed_q != 14'h0000) begin
         aout_d = neg_pol ? -17'(clamp_mv) : 17'(clamp_mv);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_out_mv <= '0;
         rotation_enable <= 1'b0;
      end else begin
         analog_out_mv <= aout_d;
         rotation_enable <= spindle_permitted & (turning | busy);
      end
   end

   // ----------------------------------------------------------------
   // standstill monitoring
   // ----------------------------------------------------------------
   logic still_q;
   logic [FD_W-1:0] base_q;
   logic signed [FD_W:0] growth;
   logic err_set;
   logic err_clr;

   assign growth = $signed({1'b0, following_distance}) - $signed({1'b0, base_q});
   assign err_set = still_q && at_standstill && (growth > $signed((FD_W+1)'(limit_q)));
   assign err_clr = wr && (addr == `OFF_STAT) && pwdata[`STAT_ERR];
   assign standstill_error = err_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         still_q <= 1'b0;
         base_q <= '0;
      end else begin
         still_q <= at_standstill;
         if (at_standstill && !still_q) begin
            base_q <= following_distance;
         end
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else if (err_set) begin
         err_q <= 1'b1;
      end else if (err_clr) begin
         err_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [31:0] rd_d;

   always_comb begin
      rd_d = '0;
      unique case (addr)
         `OFF_CFG: rd_d = 32'({cfg_q.spcfg, mode_eff, cfg_q.extra});
         `OFF_LIMIT: rd_d = 32'(limit_q);
         `OFF_MARKER: rd_d = 32'(marker_q);
         `OFF_VMAX: rd_d = 32'(vmax_q);
         `OFF_VMIN: rd_d = 32'(vmin_q);
         `OFF_VGC: rd_d = 32'(vgc_q);
         `OFF_IVAL: rd_d = 32'(ival_q);
         `OFF_PDUR: rd_d = 32'(pdur_q);
         `OFF_SCMD: rd_d = 32'({target_q, speed_q});
         `OFF_SPIN: rd_d = 32'({ccw_q, cw_q});
         `OFF_DADDR: rd_d = {12'h000, daddr_q};
         `OFF_STAT: rd_d = 32'({state_q, target_q, active_q, loop_closed, busy, err_q});
         `OFF_AOUT: rd_d = {15'h0000, analog_out_mv};
         `OFF_STOP: rd_d = {11'h000, stop_offset};
         default: begin
            for (int i = 0; i < 4; i++) begin
               if (addr == 8'(`OFF_RMAX0 + 4 * i)) begin
                  rd_d = {17'h0_0000, rmax_q[i]};
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup && !pwrite) begin
         prdata <= mapped ? rd_d : 32'h0000_0000;
      end
   end

endmodule : spindle_range_gear_change_control

`default_nettype wire

/* File: test_spindle_range_gear_change_control.sv */
// self-checking bench for the spindle block
// assumes the checker and machine interface model files compile first
`timescale 1ns/10ps
`default_nettype none

module test_spindle_range_gear_change_control
   import spindle_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus and helpers
   // ----------------------------------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic pready, pslverr, function_ready, rotation_enable, loop_closed, standstill_error;
   logic [31:0] prdata;
   logic spindle_permitted = 1'b1, at_standstill = 1'b0;
   logic [19:0] following_distance = 20'h0_0000;
   logic signed [16:0] analog_out_mv;
   logic signed [20:0] stop_offset;
   range_out_s range_select_codes;
   int n_fail = 0, samples_checked = 0;

   spindle_range_gear_change_control #(.STEP_CYCLES(4)) spindle_range_gear_change_control_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .function_ready, .spindle_permitted, .at_standstill, .following_distance,
      .analog_out_mv, .range_select_codes, .rotation_enable, .loop_closed,
      .standstill_error, .stop_offset);
   mi_model #(.HOLD(40)) mi_model_inst (.pclk, .presetn, .range_select_codes, .function_ready);

   initial begin
      forever #5 pclk = ~pclk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         n_fail++;
         $display("CHECK FAILED wait expected done seen timeout");
         complete_run();
      end
   endtask : bound

   // holds the request until pready is sampled high, takes data at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      bound(n, 50);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk("read data", r, exp);
      chk("read error", 32'(e), 32'(exp_e));
   endtask : rd_chk

   task automatic wait_cycles(input int k);
      repeat (k) @(negedge pclk);
   endtask : wait_cycles

   task automatic wait_fr(input logic v, output logic neg);
      int n;
      neg = 1'b0;
      for (n = 0; function_ready !== v && n < 500; n++) begin
         @(negedge pclk);
         if (analog_out_mv < 0) neg = 1'b1;
      end
      bound(n, 500);
   endtask : wait_fr

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_chk(8'h1C, 32'h0000_1F40, 1'b0);
      rd_chk(8'h00, 32'h0000_0000, 1'b0);
      rd_chk(8'h48, 32'h0000_0000, 1'b1);
      rd_chk(8'h02, 32'h0000_0000, 1'b1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, 32'h0000_0008 | 32'(m << 1));
         rd_chk(8'h00, 32'h0000_0008 | 32'(m << 1), 1'b0);
         chk("loop closed", 32'(loop_closed), 32'(m >> 1));
      end
      wr(8'h00, 32'h0000_0006);
      rd_chk(8'h00, 32'h0000_0000, 1'b0);
      chk("loop closed off", 32'(loop_closed), 32'h0000_0000);
      $display("test modes done");
   endtask : t_modes

   task automatic t_offset();
      wr(8'h08, 32'h0000_0064);
      wr(8'h38, 32'h0000_0019);
      wr(8'h00, 32'h0000_000B);
      wr(8'h34, 32'h0000_0004);
      wait_cycles(2);
      chk("offset plus d", 32'(stop_offset), 32'h0000_007D);
      wr(8'h00, 32'h0000_000A);
      wr(8'h34, 32'h0000_0004);
      wait_cycles(2);
      chk("offset only", 32'(stop_offset), 32'h0000_0064);
      $display("test offset done");
   endtask : t_offset

   task automatic t_standstill();
      wr(8'h04, 32'h0000_000A);
      following_distance <= 20'h0_0032;
      wait_cycles(1);
      at_standstill <= 1'b1;
      wait_cycles(2);
      following_distance <= 20'h0_003C;
      wait_cycles(3);
      chk("at limit", 32'(standstill_error), 32'h0000_0000);
      following_distance <= 20'h0_003D;
      wait_cycles(3);
      chk("over limit", 32'(standstill_error), 32'h0000_0001);
      at_standstill <= 1'b0;
      wr(8'h3C, 32'h0000_0001);
      wait_cycles(2);
      chk("cleared", 32'(standstill_error), 32'h0000_0000);
      $display("test standstill done");
   endtask : t_standstill

   task automatic gear(input logic [31:0] cmd, input logic [1:0] code,
                       input logic [31:0] aout, input logic steady);
      int n;
      logic [31:0] r;
      logic e;
      logic neg;
      wr(8'h30, cmd);
      for (n = 0; range_select_codes.code !== code && n < 100; n++) @(negedge pclk);
      bound(n, 100);
      chk("code valid", 32'(range_select_codes.valid), 32'h0000_0001);
      if (steady) chk("gear level", 32'(analog_out_mv), 32'h0000_04B0);
      wait_fr(1'b1, neg);
      apb(1'b1, 8'h30, cmd, r, e);
      chk("busy refusal", 32'(e), 32'h0000_0001);
      wait_fr(1'b0, neg);
      if (!steady) chk("alternating", 32'(neg), 32'h0000_0001);
      wait_cycles(3);
      chk("speed level", 32'(analog_out_mv), aout);
   endtask : gear

   task automatic t_ranges();
      wr(8'h0C, 32'h0000_03E8);
      wr(8'h10, 32'h0000_07D0);
      wr(8'h14, 32'h0000_0BB8);
      wr(8'h18, 32'hFFFF_F060);
      rd_chk(8'h18, 32'h0000_7060, 1'b0);
      wr(8'h20, 32'h0000_01F4);
      wr(8'h24, 32'h0000_04B0);
      wr(8'h34, 32'h0000_0001);
      wr(8'h30, 32'h0000_01F4);
      wait_cycles(3);
      chk("same range", 32'(analog_out_mv), 32'h0000_0FA0);
      chk("no code yet", 32'(range_select_codes.valid), 32'h0000_0000);
      spindle_permitted <= 1'b0;
      wait_cycles(2);
      chk("inhibit out", 32'(analog_out_mv), 32'h0000_0000);
      chk("inhibit rot", 32'(rotation_enable), 32'h0000_0000);
      spindle_permitted <= 1'b1;
      wait_cycles(3);
      chk("rotation back", 32'(rotation_enable), 32'h0000_0001);
      gear(32'h0000_05DC, 2'b01, 32'h0000_1770, 1'b1);
      wr(8'h28, 32'h0000_0001);
      wr(8'h2C, 32'h0000_0001);
      gear(32'h0001_C190, 2'b11, 32'hFFFF_FCE0, 1'b0);
      wr(8'h30, 32'h0001_C064);
      wait_cycles(3);
      chk("min clamp", 32'(analog_out_mv), 32'hFFFF_FE0C);
      $display("test ranges done");
   endtask : t_ranges

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_modes();
      t_offset();
      t_standstill();
      t_ranges();
      complete_run();
   end
endmodule : test_spindle_range_gear_change_control

bind spindle_range_gear_change_control spindle_checker spindle_checker_inst (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
   .function_ready, .spindle_permitted, .at_standstill, .range_select_codes,
   .analog_out_mv, .rotation_enable, .loop_closed, .standstill_error);

`default_nettype wire
